// ---- rtl/sltx_pkg.sv ----
// constants and types for the serial link transmit establishment block
package sltx_pkg;
  // control characters
  localparam logic [7:0] CH_R = 8'h1C;
  localparam logic [7:0] CH_A = 8'h7C;
  localparam logic [7:0] CH_Q = 8'h9C;
  localparam logic [7:0] CH_K = 8'hBC;
  localparam logic [7:0] CH_F = 8'hFC;
  // 6-bit k28 prefix at negative disparity
  localparam logic [5:0] K28_6B = 6'b001111;
  // register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_FRAMING = 12'h004;
  localparam logic [11:0] ADDR_CFG0 = 12'h008;
  localparam logic [11:0] ADDR_CFG1 = 12'h00C;
  localparam logic [11:0] ADDR_CFG2 = 12'h010;
  localparam logic [11:0] ADDR_STATUS = 12'h014;
  // control register fields
  localparam int CTRL_SCR = 0;
  localparam int CTRL_ALIGN = 1;
  localparam int CTRL_BYP = 2;
  localparam int CTRL_INV = 3;
  localparam int CTRL_SFE = 4;
  localparam int CTRL_SFV = 5;
  localparam int CTRL_FMT = 6;
  localparam int CTRL_W = 7;
  localparam logic [6:0] CTRL_RST = 7'h03;
  // framing register fields
  localparam int FR_F_LSB = 0;
  localparam int FR_K_LSB = 8;
  localparam logic [3:0] F_M1_RST = 4'h1;
  localparam logic [4:0] K_M1_RST = 5'h1F;
  // alignment sequence shape
  localparam logic [1:0] ILAS_LAST_MF = 2'h3;
  localparam logic [1:0] ILAS_CFG_MF = 2'h1;
  localparam logic [8:0] CFG_FIRST = 9'h002;
  localparam logic [8:0] CFG_END = 9'h010;
  localparam int CFG_OCTETS = 14;
  localparam logic [14:0] SCR_SEED = 15'h7FFF;
  // link phases
  typedef enum logic [1:0] {
    ST_CGS = 2'b00,
    ST_ILAS = 2'b01,
    ST_DATA = 2'b10
  } sltx_state_t;
endpackage : sltx_pkg

// ---- rtl/sltx_top.sv ----
// transmit link establishment, scrambling, substitution and 8b/10b encoding
//
// Register access over APB and the address map were left to the implementer.
module sltx_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link pins
  input wire logic link_sync_request_n,
  output logic [9:0] tx_symbol,
  output logic local_multiframe_clock,
  // sample octet stream
  input wire logic [7:0] sample_octet,
  output logic sample_ready
);

  logic [sltx_pkg::CTRL_W-1:0] ctrl;
  logic [3:0] f_m1;
  logic [4:0] k_m1;
  logic [4:0] k_eff;
  logic [31:0] cfg0;
  logic [31:0] cfg1;
  logic [7:0] cfg2;
  logic sync_m;
  logic sync_s;
  logic sync_ok;
  logic [3:0] oct_cnt_f;
  logic [4:0] frm_cnt;
  logic [8:0] oct_in_mf;
  logic frame_last;
  logic mf_last;
  sltx_pkg::sltx_state_t state;
  logic [1:0] ilas_mf;
  logic [7:0] ramp;
  logic [14:0] scr_st;
  logic [22:0] scr_res;
  logic [7:0] scr_d;
  logic [7:0] data_in;
  logic [7:0] prev_last;
  logic [7:0] cfg_arr [0:sltx_pkg::CFG_OCTETS-1];
  logic [3:0] cfg_idx;
  logic [7:0] next_oct;
  logic next_k;
  logic [7:0] oct_q;
  logic k_q;
  logic rd;
  logic [10:0] enc_res;
  logic wr_en;
  logic rd_setup;

  // apb slave, zero wait states
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= sltx_pkg::CTRL_RST;
      f_m1 <= sltx_pkg::F_M1_RST;
      k_m1 <= sltx_pkg::K_M1_RST;
      cfg0 <= 32'h0000_0000;
      cfg1 <= 32'h0000_0000;
      cfg2 <= 8'h00;
    end else if (wr_en) begin
      case (paddr)
        sltx_pkg::ADDR_CTRL: ctrl <= pwdata[sltx_pkg::CTRL_W-1:0];
        sltx_pkg::ADDR_FRAMING: begin
          f_m1 <= pwdata[sltx_pkg::FR_F_LSB +: 4];
          k_m1 <= pwdata[sltx_pkg::FR_K_LSB +: 5];
        end
        sltx_pkg::ADDR_CFG0: cfg0 <= pwdata;
        sltx_pkg::ADDR_CFG1: cfg1 <= pwdata;
        sltx_pkg::ADDR_CFG2: cfg2 <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      pslverr <= 1'b0;
      case (paddr)
        sltx_pkg::ADDR_CTRL: prdata <= {25'h0, ctrl};
        sltx_pkg::ADDR_FRAMING: prdata <= {19'h0, k_m1, 4'h0, f_m1};
        sltx_pkg::ADDR_CFG0: prdata <= cfg0;
        sltx_pkg::ADDR_CFG1: prdata <= cfg1;
        sltx_pkg::ADDR_CFG2: prdata <= {24'h0, cfg2};
        sltx_pkg::ADDR_STATUS: prdata <= {27'h0, ilas_mf, sync_ok, state};
        default: begin
          prdata <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  // sync request pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_m <= 1'b0;
      sync_s <= 1'b0;
    end else begin
      sync_m <= link_sync_request_n;
      sync_s <= sync_m;
    end
  end

  // software override of the request
  assign sync_ok = ctrl[sltx_pkg::CTRL_SFE] ? ctrl[sltx_pkg::CTRL_SFV]
                                            : sync_s;

  // local multiframe clock counters
  assign k_eff = {k_m1[4:2], 2'b11};
  assign frame_last = (oct_cnt_f == f_m1);
  assign mf_last = frame_last && (frm_cnt == k_eff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oct_cnt_f <= 4'h0;
      frm_cnt <= 5'h00;
      oct_in_mf <= 9'h000;
      local_multiframe_clock <= 1'b0;
    end else begin
      local_multiframe_clock <= mf_last;
      oct_cnt_f <= frame_last ? 4'h0 : oct_cnt_f + 4'h1;
      if (mf_last) begin
        frm_cnt <= 5'h00;
        oct_in_mf <= 9'h000;
      end else begin
        oct_in_mf <= oct_in_mf + 9'h001;
        if (frame_last) begin
          frm_cnt <= frm_cnt + 5'h01;
        end
      end
    end
  end

  // link phase machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= sltx_pkg::ST_CGS;
    end else if (!sync_ok) begin
      state <= sltx_pkg::ST_CGS;
    end else begin
      case (state)
        sltx_pkg::ST_CGS: begin
          if (mf_last) begin
            state <= sltx_pkg::ST_ILAS;
          end
        end
        sltx_pkg::ST_ILAS: begin
          if (mf_last && ilas_mf == sltx_pkg::ILAS_LAST_MF) begin
            state <= sltx_pkg::ST_DATA;
          end
        end
        sltx_pkg::ST_DATA: state <= sltx_pkg::ST_DATA;
        default: state <= sltx_pkg::ST_CGS;
      endcase
    end
  end

  // alignment multiframe index and ramp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ilas_mf <= 2'h0;
      ramp <= 8'h00;
    end else if (state != sltx_pkg::ST_ILAS) begin
      ilas_mf <= 2'h0;
      ramp <= 8'h00;
    end else begin
      ramp <= ramp + 8'h01;
      if (mf_last) begin
        ilas_mf <= ilas_mf + 2'h1;
      end
    end
  end

  // link configuration octets, parameters held as value minus one
  always_comb begin
    cfg_arr[0] = cfg0[7:0];
    cfg_arr[1] = {4'h0, cfg0[11:8]};
    cfg_arr[2] = {3'h0, cfg0[20:16]};
    cfg_arr[3] = {ctrl[sltx_pkg::CTRL_SCR], 2'b00, cfg0[28:24]};
    cfg_arr[4] = {4'h0, f_m1};
    cfg_arr[5] = {3'h0, k_eff};
    cfg_arr[6] = cfg1[7:0];
    cfg_arr[7] = cfg1[15:8];
    cfg_arr[8] = cfg1[23:16];
    cfg_arr[9] = cfg1[31:24];
    cfg_arr[10] = cfg2;
    cfg_arr[11] = 8'h00;
    cfg_arr[12] = 8'h00;
    cfg_arr[13] = 8'h00;
    for (int i = 0; i < sltx_pkg::CFG_OCTETS - 1; i++) begin
      cfg_arr[13] = cfg_arr[13] + cfg_arr[i];
    end
  end

  assign cfg_idx = 4'(oct_in_mf - sltx_pkg::CFG_FIRST);

  // self-synchronising scrambler, msb first
  function automatic logic [22:0] scramble(input logic [7:0] d,
                                           input logic [14:0] s);
    logic [14:0] st;
    logic [7:0] o;
    logic b;
    st = s;
    o = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      b = d[i] ^ st[13] ^ st[14];
      o[i] = b;
      st = {st[13:0], b};
    end
    return {st, o};
  endfunction : scramble

  // offset binary flips the sample msb carried in even octets
  assign data_in = sample_octet
                 ^ {ctrl[sltx_pkg::CTRL_FMT] & ~oct_cnt_f[0], 7'h00};
  assign scr_res = scramble(data_in, scr_st);
  assign scr_d = scr_res[7:0];
  assign sample_ready = (state == sltx_pkg::ST_DATA);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scr_st <= sltx_pkg::SCR_SEED;
    end else if (sample_ready && ctrl[sltx_pkg::CTRL_SCR]) begin
      scr_st <= scr_res[22:8];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_last <= 8'h00;
    end else if (sample_ready && frame_last) begin
      prev_last <= data_in;
    end
  end

  // octet and control flag selection
  always_comb begin
    next_oct = sltx_pkg::CH_K;
    next_k = 1'b1;
    case (state)
      sltx_pkg::ST_CGS: begin
        next_oct = sltx_pkg::CH_K;
        next_k = 1'b1;
      end
      sltx_pkg::ST_ILAS: begin
        if (oct_in_mf == 9'h000) begin
          next_oct = sltx_pkg::CH_R;
        end else if (mf_last) begin
          next_oct = sltx_pkg::CH_A;
        end else if (ilas_mf == sltx_pkg::ILAS_CFG_MF
                     && oct_in_mf == 9'h001) begin
          next_oct = sltx_pkg::CH_Q;
        end else if (ilas_mf == sltx_pkg::ILAS_CFG_MF
                     && oct_in_mf >= sltx_pkg::CFG_FIRST
                     && oct_in_mf < sltx_pkg::CFG_END) begin
          next_oct = cfg_arr[cfg_idx];
          next_k = 1'b0;
        end else begin
          next_oct = ramp;
          next_k = 1'b0;
        end
      end
      sltx_pkg::ST_DATA: begin
        next_k = 1'b0;
        if (ctrl[sltx_pkg::CTRL_SCR]) begin
          next_oct = scr_d;
          if (ctrl[sltx_pkg::CTRL_ALIGN] && frame_last) begin
            if (mf_last && scr_d == sltx_pkg::CH_A) begin
              next_k = 1'b1;
            end else if (scr_d == sltx_pkg::CH_F) begin
              next_k = 1'b1;
            end
          end
        end else begin
          next_oct = data_in;
          if (ctrl[sltx_pkg::CTRL_ALIGN] && frame_last
              && data_in == prev_last) begin
            next_k = 1'b1;
            next_oct = mf_last ? sltx_pkg::CH_A : sltx_pkg::CH_F;
          end
        end
      end
      default: begin
        next_oct = sltx_pkg::CH_K;
        next_k = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oct_q <= sltx_pkg::CH_K;
      k_q <= 1'b1;
    end else begin
      oct_q <= next_oct;
      k_q <= next_k;
    end
  end

  // 8b/10b encoder, returns {next disparity, abcdei fghj}
  function automatic logic [10:0] encode(input logic [7:0] o,
                                         input logic k,
                                         input logic rdin);
    logic [5:0] c6;
    logic [3:0] c4;
    logic [9:0] c10;
    logic r;
    logic alt;
    logic [4:0] x;
    logic [2:0] y;
    x = o[4:0];
    y = o[7:5];
    r = rdin;
    c6 = sltx_pkg::K28_6B;
    c4 = 4'b0100;
    alt = 1'b0;
    if (k) begin
      case (y)
        3'h0: c4 = 4'b0100;
        3'h1: c4 = 4'b1001;
        3'h2: c4 = 4'b0101;
        3'h3: c4 = 4'b0011;
        3'h4: c4 = 4'b0010;
        3'h5: c4 = 4'b1010;
        3'h6: c4 = 4'b0110;
        default: c4 = 4'b1000;
      endcase
      c10 = {c6, c4} ^ {10{r}};
      if ($countones(c10) != 5) begin
        r = ~r;
      end
    end else begin
      case (x)
        5'd0: c6 = 6'b100111;
        5'd1: c6 = 6'b011101;
        5'd2: c6 = 6'b101101;
        5'd3: c6 = 6'b110001;
        5'd4: c6 = 6'b110101;
        5'd5: c6 = 6'b101001;
        5'd6: c6 = 6'b011001;
        5'd7: c6 = 6'b111000;
        5'd8: c6 = 6'b111001;
        5'd9: c6 = 6'b100101;
        5'd10: c6 = 6'b010101;
        5'd11: c6 = 6'b110100;
        5'd12: c6 = 6'b001101;
        5'd13: c6 = 6'b101100;
        5'd14: c6 = 6'b011100;
        5'd15: c6 = 6'b010111;
        5'd16: c6 = 6'b011011;
        5'd17: c6 = 6'b100011;
        5'd18: c6 = 6'b010011;
        5'd19: c6 = 6'b110010;
        5'd20: c6 = 6'b001011;
        5'd21: c6 = 6'b101010;
        5'd22: c6 = 6'b011010;
        5'd23: c6 = 6'b111010;
        5'd24: c6 = 6'b110011;
        5'd25: c6 = 6'b100110;
        5'd26: c6 = 6'b010110;
        5'd27: c6 = 6'b110110;
        5'd28: c6 = 6'b001110;
        5'd29: c6 = 6'b101110;
        5'd30: c6 = 6'b011110;
        default: c6 = 6'b101011;
      endcase
      if (r && ($countones(c6) != 3 || x == 5'd7)) begin
        c6 = ~c6;
      end
      if ($countones(c6) != 3) begin
        r = ~r;
      end
      alt = (y == 3'h7)
          && ((!r && (x == 5'd17 || x == 5'd18 || x == 5'd20))
          || (r && (x == 5'd11 || x == 5'd13 || x == 5'd14)));
      case (y)
        3'h0: c4 = 4'b1011;
        3'h1: c4 = 4'b1001;
        3'h2: c4 = 4'b0101;
        3'h3: c4 = 4'b1100;
        3'h4: c4 = 4'b1101;
        3'h5: c4 = 4'b1010;
        3'h6: c4 = 4'b0110;
        default: c4 = alt ? 4'b0111 : 4'b1110;
      endcase
      if (r && ($countones(c4) != 2 || y == 3'h3)) begin
        c4 = ~c4;
      end
      if ($countones(c4) != 2) begin
        r = ~r;
      end
      c10 = {c6, c4};
    end
    return {r, c10};
  endfunction : encode

  assign enc_res = encode(oct_q, k_q, rd);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_symbol <= 10'h000;
      rd <= 1'b0;
    end else if (ctrl[sltx_pkg::CTRL_BYP]) begin
      tx_symbol <= {k_q, 1'b0, oct_q}
                 ^ {10{ctrl[sltx_pkg::CTRL_INV]}};
    end else begin
      tx_symbol <= enc_res[9:0] ^ {10{ctrl[sltx_pkg::CTRL_INV]}};
      rd <= enc_res[10];
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence ilas_entry_s;
    state == sltx_pkg::ST_CGS && sync_ok && mf_last;
  endsequence
  sequence ilas_done_s;
    state == sltx_pkg::ST_ILAS && ilas_mf == sltx_pkg::ILAS_LAST_MF
      && mf_last && sync_ok;
  endsequence

  cgs_comma_a: assert property (
    state == sltx_pkg::ST_CGS |=> k_q && oct_q == sltx_pkg::CH_K)
    else $error("non comma during code group sync");
  sync_restart_a: assert property (
    !sync_ok |=> state == sltx_pkg::ST_CGS ##1 oct_q == sltx_pkg::CH_K)
    else $error("sync request did not restart commas");
  phase_abandon_a: assert property (
    state != sltx_pkg::ST_CGS && !sync_ok
      |=> state == sltx_pkg::ST_CGS && !sample_ready)
    else $error("phase not abandoned on sync loss");
  ilas_start_a: assert property (
    ilas_entry_s |=> state == sltx_pkg::ST_ILAS && oct_in_mf == 9'h000
      && local_multiframe_clock)
    else $error("alignment not started on boundary");
  ilas_span_a: assert property (
    ilas_done_s |=> state == sltx_pkg::ST_DATA
      ##1 (!k_q || oct_q != sltx_pkg::CH_R))
    else $error("alignment sequence length wrong");
  ilas_open_a: assert property (
    state == sltx_pkg::ST_ILAS && oct_in_mf == 9'h000
      |=> k_q && oct_q == sltx_pkg::CH_R)
    else $error("multiframe not opened with R");
  ilas_close_a: assert property (
    state == sltx_pkg::ST_ILAS && mf_last && oct_in_mf != 9'h000
      |=> k_q && oct_q == sltx_pkg::CH_A)
    else $error("multiframe not closed with A");
  ilas_ramp_a: assert property (
    state == sltx_pkg::ST_ILAS && ilas_mf == 2'h0 && oct_in_mf != 9'h000
      && !mf_last |=> !k_q && oct_q == $past(ramp))
    else $error("ramp data wrong in first multiframe");
  cfg_marker_a: assert property (
    state == sltx_pkg::ST_ILAS && ilas_mf == sltx_pkg::ILAS_CFG_MF
      && oct_in_mf == 9'h001 && !mf_last
      |=> k_q && oct_q == sltx_pkg::CH_Q)
    else $error("Q missing in second multiframe");
  scr_bypass_a: assert property (
    state == sltx_pkg::ST_ILAS |=> $stable(scr_st))
    else $error("scrambler advanced during alignment");
  frame_sub_a: assert property (
    sample_ready && ctrl[sltx_pkg::CTRL_SCR] && ctrl[sltx_pkg::CTRL_ALIGN]
      && frame_last && !mf_last && scr_d == sltx_pkg::CH_F
      |=> k_q && oct_q == sltx_pkg::CH_F)
    else $error("F not substituted at frame end");
  comma_disp_a: assert property (
    !ctrl[sltx_pkg::CTRL_BYP] && !ctrl[sltx_pkg::CTRL_INV] && k_q
      && oct_q == sltx_pkg::CH_K && !rd |=> tx_symbol == 10'h0FA && rd)
    else $error("comma disparity encoding wrong");

endmodule : sltx_top

// ---- test/sltx_rx_model.sv ----
// receiver-side model: comma lock and sync request
module sltx_rx_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link
  input wire logic [9:0] tx_symbol,
  output logic link_sync_request_n,
  // bench control
  input wire logic hold_req,
  input wire logic slow
);
  logic [3:0] k_run;
  logic is_k;
  // commas of both disparities, plus the bypass forms
  assign is_k = tx_symbol inside {10'h0FA, 10'h305, 10'h2BC, 10'h143};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      k_run <= 4'h0;
    end else if (!is_k || hold_req) begin
      k_run <= 4'h0;
    end else if (k_run != 4'hF) begin
      k_run <= k_run + 4'h1;
    end
  end
  // release after four commas in a row, eight when slow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_sync_request_n <= 1'b0;
    end else if (hold_req) begin
      link_sync_request_n <= 1'b0;
    end else if (k_run >= (slow ? 4'h8 : 4'h4)) begin
      link_sync_request_n <= 1'b1;
    end
  end
endmodule : sltx_rx_model

// ---- test/tb_top.sv ----
// self-checking bench for the link transmit block
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [9:0] KR = {2'b10, sltx_pkg::CH_R};
  localparam logic [9:0] KA = {2'b10, sltx_pkg::CH_A};
  localparam logic [9:0] KQ = {2'b10, sltx_pkg::CH_Q};
  localparam logic [9:0] KK = {2'b10, sltx_pkg::CH_K};
  localparam logic [9:0] KF = {2'b10, sltx_pkg::CH_F};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic link_sync_request_n, local_multiframe_clock, sample_ready;
  logic [9:0] tx_symbol;
  logic [7:0] sample_octet, fix_oct;
  logic hold_req, slow, ramp_on;
  logic [1:0] lm_d;
  int error_cnt, cmp_count, cnt;

  sltx_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_sync_request_n(link_sync_request_n), .tx_symbol(tx_symbol),
    .local_multiframe_clock(local_multiframe_clock),
    .sample_octet(sample_octet), .sample_ready(sample_ready));
  sltx_rx_model rx (.pclk(pclk), .presetn(presetn), .tx_symbol(tx_symbol),
    .link_sync_request_n(link_sync_request_n), .hold_req(hold_req),
    .slow(slow));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // octet source and multiframe pulse history
  always @(posedge pclk) begin
    if (!presetn) begin
      lm_d <= 2'b00;
      sample_octet <= 8'h00;
    end else begin
      lm_d <= {lm_d[0], local_multiframe_clock};
      sample_octet <= ramp_on ? sample_octet + 8'h01 : fix_oct;
    end
  end

  task chk_sym(input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t symbol %h expected %h", $time, got, exp);
    end
  endtask : chk_sym

  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  task step;
    @(posedge pclk);
    #1;
  endtask : step

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i == 50) begin
      error_cnt++;
      $display("[FAIL] %0t no ready on register bus", $time);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wait_r;
    cnt = 0;
    while (tx_symbol !== KR && cnt < 300) begin
      step;
      cnt++;
    end
  endtask : wait_r

  task t_regs;
    apb(1'b0, sltx_pkg::ADDR_CTRL, 32'h0);
    chk_reg(rdat, 32'h00000003);
    chk_reg({31'h0, rerr}, 32'h0);
    apb(1'b0, sltx_pkg::ADDR_FRAMING, 32'h0);
    chk_reg(rdat, 32'h00001F01);
    apb(1'b0, sltx_pkg::ADDR_STATUS, 32'h0);
    chk_reg(rdat, 32'h00000000);
    apb(1'b0, 12'h020, 32'h0);
    chk_reg({rerr, rdat[30:0]}, 32'h80000000);
    apb(1'b1, sltx_pkg::ADDR_FRAMING, 32'h00001300);
    apb(1'b0, sltx_pkg::ADDR_FRAMING, 32'h0);
    chk_reg(rdat, 32'h00001300);
    apb(1'b1, sltx_pkg::ADDR_CFG0, 32'h000000A5);
  endtask : t_regs

  task t_cgs;
    logic [9:0] prev;
    step;
    prev = tx_symbol;
    chk_reg({31'h0, prev inside {10'h0FA, 10'h305}}, 32'h1);
    repeat (6) begin
      step;
      chk_sym(tx_symbol, ~prev);
      prev = tx_symbol;
    end
  endtask : t_cgs

  task t_ilas;
    int mf, s;
    for (int n = 0; n < 80; n++) begin
      mf = n / 20;
      s = n % 20;
      if (s == 0) begin
        chk_sym(tx_symbol, KR);
        chk_reg({31'h0, lm_d[1]}, 32'h1);
      end else if (s == 19) chk_sym(tx_symbol, KA);
      else if (mf == 1 && s == 1) chk_sym(tx_symbol, KQ);
      else if (mf == 1 && s == 2) chk_sym(tx_symbol, 10'h0A5);
      else if (mf == 1 && s == 6) chk_sym(tx_symbol, 10'h000);
      else if (mf == 1 && s == 7) chk_sym(tx_symbol, 10'h013);
      else if (mf != 1 || s > 15) chk_sym(tx_symbol, 10'(n));
      step;
    end
  endtask : t_ilas

  task t_scr;
    logic [14:0] h;
    logic [7:0] y, d, pd;
    int s;
    h = '0;
    pd = 8'h00;
    for (int n = 80; n < 1080; n++) begin
      s = n % 20;
      y = tx_symbol[7:0];
      if (tx_symbol[9] && s != 19) chk_sym(tx_symbol, KF);
      if (!tx_symbol[9])
        chk_reg({31'h0, y == 8'hFC || (s == 19 && y == 8'h7C)}, 32'h0);
      // receiver descrambler, msb first
      for (int b = 7; b >= 0; b--) begin
        d[b] = y[b] ^ h[13] ^ h[14];
        h = {h[13:0], y[b]};
      end
      if (n > 83) chk_reg({24'h0, d}, {24'h0, pd + 8'h01});
      pd = d;
      step;
    end
  endtask : t_scr

  task t_resync(input logic [31:0] ctrl);
    int i;
    @(posedge pclk);
    hold_req <= 1'b1;
    slow <= 1'b1;
    i = 0;
    do begin
      step;
      i++;
    end while (tx_symbol !== KK && i < 20);
    chk_reg({31'h0, i <= 8}, 32'h1);
    chk_reg({31'h0, sample_ready}, 32'h0);
    apb(1'b1, sltx_pkg::ADDR_CTRL, ctrl);
    repeat (8) begin
      step;
      chk_sym(tx_symbol, KK);
    end
    @(posedge pclk);
    hold_req <= 1'b0;
    ramp_on <= 1'b0;
    fix_oct <= 8'h55;
  endtask : t_resync

  task t_unscr;
    for (int n = 80; n < 120; n++) begin
      if (n > 80) chk_sym(tx_symbol, (n % 20 == 19) ? KA : KF);
      step;
    end
    apb(1'b1, sltx_pkg::ADDR_CTRL, 32'h00000044);
    repeat (4) step;
    repeat (8) begin
      step;
      chk_sym(tx_symbol, 10'h0D5);
    end
    apb(1'b1, sltx_pkg::ADDR_CTRL, 32'h00000040);
    repeat (4) step;
    repeat (4) begin
      step;
      chk_sym(tx_symbol, 10'h2A6);
    end
  endtask : t_unscr

  task t_force;
    apb(1'b1, sltx_pkg::ADDR_CTRL, 32'h0000001C);
    repeat (10) step;
    chk_sym(tx_symbol, ~KK);
    chk_reg({31'h0, sample_ready}, 32'h0);
    apb(1'b1, sltx_pkg::ADDR_CTRL, 32'h00000034);
    wait_r;
    chk_reg({31'h0, cnt < 40}, 32'h1);
  endtask : t_force

  initial begin
    #100000;
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    hold_req = 1'b1;
    slow = 1'b0;
    ramp_on = 1'b1;
    fix_oct = 8'h00;
    error_cnt = 0;
    cmp_count = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_cgs;
    apb(1'b1, sltx_pkg::ADDR_CTRL, 32'h00000007);
    @(posedge pclk);
    hold_req <= 1'b0;
    wait_r;
    chk_reg({31'h0, cnt <= 32}, 32'h1);
    t_ilas;
    t_scr;
    t_resync(32'h00000006);
    wait_r;
    t_ilas;
    t_unscr;
    t_force;
    end_sim;
  end
endmodule : tb_top
